/* include/argw_cfg.svh */
`ifndef ARGW_CFG_SVH
`define ARGW_CFG_SVH

// Angle and compare word layout.
`define ARGW_ANGLE_W        12
`define ARGW_WORD_W         16
`define ARGW_LEVEL_BIT      15
`define ARGW_HALF_TURN      12'h800
`define ARGW_ANGLE_ZERO     12'h000

// Table geometry: three phases of thirty-two words.
`define ARGW_AREAS          6'h20
`define ARGW_TOTAL_WORDS    96
`define ARGW_ADDR_W         7
`define ARGW_LAST_WORD      7'h5F
`define ARGW_PHASE_W_IDX    2'h2
`define ARGW_PHASE_BAD      2'h3

// Control encodings.
`define ARGW_MODE_SAWTOOTH  2'h0
`define ARGW_DIR_POSITIVE   1'h0
`define ARGW_XFER_BATCH     1'h0
`define ARGW_PHASE_EN_ALL   2'h3
`define ARGW_CLEAR_ALL      3'h7

`endif

/* include/argw_pkg.sv */
package argw_pkg;

    typedef enum logic [1:0] {
        S_IDLE  = 2'h0,
        S_READ  = 2'h1,
        S_CHECK = 2'h3,
        S_COPY  = 2'h2
    } scan_state_e;

endpackage

/* hw/compare_word_mem.sv */
`timescale 1ns/1ps

module compare_word_mem #(
    parameter int WIDTH  = 16,
    parameter int DEPTH  = 96,
    parameter int ADDR_W = 7
)(
    // Clock and reset.
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // Write port.
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [WIDTH-1:0]  wrData,
    // Read port, data one cycle after the request.
    input  wire logic              rdEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [WIDTH-1:0]  rdData
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= '0;
        end
        else if (wrEn && int'(wrAddr) < DEPTH)
            mem[wrAddr] <= wrData;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rdData <= '0;
        else if (rdEn)
            rdData <= (int'(rdAddr) < DEPTH) ? mem[rdAddr] : '0;
    end

endmodule

/* hw/angle_rectangle_wave_gen.sv */
`timescale 1ns/1ps
`include "argw_cfg.svh"
// Notes on behaviour
// - Word top bit is the area level, low twelve bits the area end angle.
// - Area zero runs from the last used end angle through zero to its end.
// - Channel-structure bit one gives each phase its own table and output.
// - Waveform mode zero-zero selects sawtooth comparison.
// - Rotation direction zero uses the angle as advancing positively.
// - Transfer mode zero is batch: written words never take effect alone.
// - A clear value of seven clears all pending match interrupt status.
// - Lower-half enable allows match interrupts only below 180 degrees.
// - Phase-enable zero-zero allows match interrupts from phase U only.
// - Per-phase select bit n requests an interrupt on area n match.
// - A clear value of seven clears all pending conversion trigger status.
// - Lower-half enable allows conversion triggers only below 180 degrees.
// - Phase-enable zero-zero lets only phase U matches make triggers.
// - Per-phase select bit n emits a trigger on area n match.
// - Common and per-phase offsets are added to the angle; zero changes nothing.
// - Per-phase area counts set the used words; thirty-two uses all.
// - A transfer request applies staged words of all three phases together.
// - The generator runs only while the unit enable is one.
// - In batch mode, written words sit in a holding table until the transfer.
// - Word n sets both the end angle and the level of area n.
// - Thirty-two word locations reach ninety-six words via phase selects.
module angle_rectangle_wave_gen (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Electrical angle from the angle generator.
    input  wire logic [11:0] elecAngle,
    input  wire logic        elecAngleValid,
    // Unit control.
    input  wire logic        unitEnable,
    input  wire logic        channelIndependent,
    input  wire logic [1:0]  waveformModeCtrl,
    input  wire logic        rotationDirection,
    input  wire logic        compareTransferMode,
    input  wire logic        transferGo,
    // Match interrupt control.
    input  wire logic        matchIrqClearWr,
    input  wire logic [2:0]  matchIrqClearData,
    input  wire logic        irqLowerHalfEnable,
    input  wire logic [1:0]  irqPhaseEnable,
    input  wire logic [31:0] phaseUIrqSelect,
    input  wire logic [31:0] phaseVIrqSelect,
    input  wire logic [31:0] phaseWIrqSelect,
    // Conversion trigger control.
    input  wire logic        convTriggerClearWr,
    input  wire logic [2:0]  convTriggerClearData,
    input  wire logic        trigLowerHalfEnable,
    input  wire logic [1:0]  trigPhaseEnable,
    input  wire logic [31:0] phaseUTriggerSelect,
    input  wire logic [31:0] phaseVTriggerSelect,
    input  wire logic [31:0] phaseWTriggerSelect,
    // Angle offsets.
    input  wire logic [11:0] commonAngleOffset,
    input  wire logic [11:0] phaseUAngleOffset,
    input  wire logic [11:0] phaseVAngleOffset,
    input  wire logic [11:0] phaseWAngleOffset,
    // Area counts.
    input  wire logic [5:0]  phaseUAreaCount,
    input  wire logic [5:0]  phaseVAreaCount,
    input  wire logic [5:0]  phaseWAreaCount,
    // Compare word window.
    input  wire logic [1:0]  writePhaseSelect,
    input  wire logic [1:0]  readPhaseSelect,
    input  wire logic        wordWrEn,
    input  wire logic [4:0]  wordWrIndex,
    input  wire logic [15:0] wordWrData,
    input  wire logic        wordRdEn,
    input  wire logic [4:0]  wordRdIndex,
    output logic      [15:0] wordRdData,
    output logic             wordRdValid,
    // Phase levels to the dead-time timer.
    output logic             phaseUOut,
    output logic             phaseVOut,
    output logic             phaseWOut,
    // Events.
    output logic      [2:0]  matchIrqStatus,
    output logic             matchIrq,
    output logic      [2:0]  convTriggerStatus,
    output logic             convTrigger
);

    ////////////////////////////////////////////////////////////////////////////
    argw_pkg::scan_state_e state_reg;
    logic [1:0]  phaseIdx_reg;
    logic [4:0]  areaIdx_reg;
    logic [11:0] angle_reg;
    logic [11:0] scanAngle_reg;
    logic        area0Level_reg;
    logic [4:0]  curArea_reg [3];
    logic [2:0]  haveArea_reg;
    logic [2:0]  outLevel_reg;
    logic        rescan_reg;
    logic        enablePrev_reg;
    logic        xferReq_reg;
    logic [6:0]  copyIdx_reg;
    logic [6:0]  copyWrAddr_reg;
    logic        copyWrPend_reg;
    logic        swRdPend_reg;
    logic [15:0] wordRdData_reg;
    logic        wordRdValid_reg;
    logic [2:0]  matchIrqStatus_reg;
    logic [2:0]  convTriggerStatus_reg;
    logic        matchIrq_reg;
    logic        convTrigger_reg;

    logic [15:0] stageRdData;
    logic [15:0] activeRdData;
    logic [11:0] dirAngle;
    logic [11:0] phaseOffset;
    logic [11:0] adjAngle;
    logic [5:0]  areaCount;
    logic [5:0]  effCount;
    logic [31:0] irqSel;
    logic [31:0] trigSel;
    logic [4:0]  oldArea;
    logic [1:0]  tablePhase;
    logic        hit;
    logic        found;
    logic        newLevel;
    logic [4:0]  newArea;
    logic        areaEvent;
    logic [2:0]  irqSet;
    logic [2:0]  trigSet;
    logic        wrOk;
    logic        swRdAcc;
    logic        copyStart;
    logic        scanStart;

    ////////////////////////////////////////////////////////////////////////////
    // Holding table written by software, active table read by the comparator.
    assign wrOk    = wordWrEn && writePhaseSelect != `ARGW_PHASE_BAD;
    assign swRdAcc = wordRdEn && state_reg != argw_pkg::S_COPY && readPhaseSelect != `ARGW_PHASE_BAD;

    compare_word_mem #(.WIDTH(`ARGW_WORD_W), .DEPTH(`ARGW_TOTAL_WORDS), .ADDR_W(`ARGW_ADDR_W)) stageMem (
        .clk_sys (clk_sys),
        .reset   (reset),
        .wrEn    (wrOk),
        .wrAddr  ({writePhaseSelect, wordWrIndex}),
        .wrData  (wordWrData),
        .rdEn    (swRdAcc || state_reg == argw_pkg::S_COPY),
        .rdAddr  (state_reg == argw_pkg::S_COPY ? copyIdx_reg : {readPhaseSelect, wordRdIndex}),
        .rdData  (stageRdData)
    );

    // Immediate mode also writes the active table; batch mode never does.
    compare_word_mem #(.WIDTH(`ARGW_WORD_W), .DEPTH(`ARGW_TOTAL_WORDS), .ADDR_W(`ARGW_ADDR_W)) activeMem (
        .clk_sys (clk_sys),
        .reset   (reset),
        .wrEn    (copyWrPend_reg || (wrOk && compareTransferMode != `ARGW_XFER_BATCH)),
        .wrAddr  (copyWrPend_reg ? copyWrAddr_reg : {writePhaseSelect, wordWrIndex}),
        .wrData  (copyWrPend_reg ? stageRdData : wordWrData),
        .rdEn    (state_reg == argw_pkg::S_READ),
        .rdAddr  ({tablePhase, areaIdx_reg}),
        .rdData  (activeRdData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-phase selection and offset-adjusted angle.
    always_comb
    begin
        tablePhase = channelIndependent ? phaseIdx_reg : 2'h0;
        dirAngle   = (rotationDirection == `ARGW_DIR_POSITIVE) ? scanAngle_reg
                   : 12'(`ARGW_ANGLE_ZERO - scanAngle_reg);
        case (phaseIdx_reg)
            2'h0:
            begin
                phaseOffset = phaseUAngleOffset;
                areaCount   = phaseUAreaCount;
                irqSel      = phaseUIrqSelect;
                trigSel     = phaseUTriggerSelect;
            end
            2'h1:
            begin
                phaseOffset = phaseVAngleOffset;
                areaCount   = phaseVAreaCount;
                irqSel      = phaseVIrqSelect;
                trigSel     = phaseVTriggerSelect;
            end
            default:
            begin
                phaseOffset = phaseWAngleOffset;
                areaCount   = phaseWAreaCount;
                irqSel      = phaseWIrqSelect;
                trigSel     = phaseWTriggerSelect;
            end
        endcase
        adjAngle = 12'(dirAngle + commonAngleOffset + phaseOffset);
        effCount = (areaCount == 6'h00 || areaCount > `ARGW_AREAS) ? `ARGW_AREAS : areaCount;
        oldArea  = curArea_reg[phaseIdx_reg];
    end

    // The angle sits in the first area whose end lies above it, else area zero.
    always_comb
    begin
        hit       = adjAngle < activeRdData[11:0];
        found     = hit || areaIdx_reg == 5'(effCount - 6'h01);
        newArea   = hit ? areaIdx_reg : 5'h00;
        newLevel  = (hit || areaIdx_reg == 5'h00) ? activeRdData[`ARGW_LEVEL_BIT] : area0Level_reg;
        areaEvent = state_reg == argw_pkg::S_CHECK && found && unitEnable
                 && haveArea_reg[phaseIdx_reg] && newArea != oldArea;
        irqSet    = 3'h0;
        trigSet   = 3'h0;
        if (areaEvent && irqSel[oldArea]
            && (irqPhaseEnable == `ARGW_PHASE_EN_ALL || irqPhaseEnable == phaseIdx_reg)
            && (!irqLowerHalfEnable || adjAngle < `ARGW_HALF_TURN))
            irqSet = 3'(3'h1 << phaseIdx_reg);
        if (areaEvent && trigSel[oldArea]
            && (trigPhaseEnable == `ARGW_PHASE_EN_ALL || trigPhaseEnable == phaseIdx_reg)
            && (!trigLowerHalfEnable || adjAngle < `ARGW_HALF_TURN))
            trigSet = 3'(3'h1 << phaseIdx_reg);
    end

    ////////////////////////////////////////////////////////////////////////////
    assign copyStart = state_reg == argw_pkg::S_IDLE && xferReq_reg && !copyWrPend_reg;
    assign scanStart = state_reg == argw_pkg::S_IDLE && !xferReq_reg && !copyWrPend_reg && unitEnable
                    && waveformModeCtrl == `ARGW_MODE_SAWTOOTH
                    && (angle_reg != scanAngle_reg || rescan_reg);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            angle_reg <= `ARGW_ANGLE_ZERO;
        else if (elecAngleValid)
            angle_reg <= elecAngle;
    end

    // Pending transfer: a request during a scan waits for it, so all three apply together.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            xferReq_reg <= 1'b0;
        else if (transferGo && compareTransferMode == `ARGW_XFER_BATCH)
            xferReq_reg <= 1'b1;
        else if (copyStart)
            xferReq_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rescan_reg     <= 1'b1;
            enablePrev_reg <= 1'b0;
        end
        else
        begin
            enablePrev_reg <= unitEnable;
            if ((copyWrPend_reg && state_reg != argw_pkg::S_COPY)
                || (wrOk && compareTransferMode != `ARGW_XFER_BATCH) || (unitEnable && !enablePrev_reg))
                rescan_reg <= 1'b1;
            else if (scanStart)
                rescan_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_reg      <= argw_pkg::S_IDLE;
            phaseIdx_reg   <= 2'h0;
            areaIdx_reg    <= 5'h00;
            scanAngle_reg  <= `ARGW_ANGLE_ZERO;
            area0Level_reg <= 1'b0;
            copyIdx_reg    <= 7'h00;
        end
        else
        begin
            case (state_reg)
                argw_pkg::S_IDLE:
                begin
                    if (copyStart)
                    begin
                        state_reg   <= argw_pkg::S_COPY;
                        copyIdx_reg <= 7'h00;
                    end
                    else if (scanStart)
                    begin
                        state_reg     <= argw_pkg::S_READ;
                        phaseIdx_reg  <= 2'h0;
                        areaIdx_reg   <= 5'h00;
                        scanAngle_reg <= angle_reg;
                    end
                end
                argw_pkg::S_READ:
                    state_reg <= argw_pkg::S_CHECK;
                argw_pkg::S_CHECK:
                begin
                    if (areaIdx_reg == 5'h00)
                        area0Level_reg <= activeRdData[`ARGW_LEVEL_BIT];
                    if (!found)
                    begin
                        areaIdx_reg <= 5'(areaIdx_reg + 5'h01);
                        state_reg   <= argw_pkg::S_READ;
                    end
                    else if (phaseIdx_reg == `ARGW_PHASE_W_IDX)
                        state_reg <= argw_pkg::S_IDLE;
                    else
                    begin
                        phaseIdx_reg <= 2'(phaseIdx_reg + 2'h1);
                        areaIdx_reg  <= 5'h00;
                        state_reg    <= argw_pkg::S_READ;
                    end
                end
                argw_pkg::S_COPY:
                begin
                    copyIdx_reg <= 7'(copyIdx_reg + 7'h01);
                    if (copyIdx_reg == `ARGW_LAST_WORD)
                        state_reg <= argw_pkg::S_IDLE;
                end
                default:
                    state_reg <= argw_pkg::S_IDLE;
            endcase
        end
    end

    // Copy pipeline: word read at one edge is written to the active table at the next.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            copyWrPend_reg <= 1'b0;
            copyWrAddr_reg <= 7'h00;
        end
        else
        begin
            copyWrPend_reg <= state_reg == argw_pkg::S_COPY;
            copyWrAddr_reg <= copyIdx_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys)
    begin
        if (reset || !unitEnable)
        begin
            outLevel_reg <= 3'h0;
            haveArea_reg <= 3'h0;
            for (int p = 0; p < 3; p++)
                curArea_reg[p] <= 5'h00;
        end
        else if (state_reg == argw_pkg::S_CHECK && found)
        begin
            outLevel_reg[phaseIdx_reg] <= newLevel;
            curArea_reg[phaseIdx_reg]  <= newArea;
            haveArea_reg[phaseIdx_reg] <= 1'b1;
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            matchIrqStatus_reg    <= 3'h0;
            convTriggerStatus_reg <= 3'h0;
            matchIrq_reg          <= 1'b0;
            convTrigger_reg       <= 1'b0;
        end
        else
        begin
            matchIrqStatus_reg    <= (matchIrqStatus_reg & ~(matchIrqClearWr ? matchIrqClearData : 3'h0))
                                   | irqSet;
            convTriggerStatus_reg <= (convTriggerStatus_reg & ~(convTriggerClearWr ? convTriggerClearData : 3'h0))
                                   | trigSet;
            matchIrq_reg          <= |irqSet;
            convTrigger_reg       <= |trigSet;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            swRdPend_reg    <= 1'b0;
            wordRdValid_reg <= 1'b0;
            wordRdData_reg  <= 16'h0000;
        end
        else
        begin
            swRdPend_reg    <= swRdAcc;
            wordRdValid_reg <= swRdPend_reg;
            if (swRdPend_reg)
                wordRdData_reg <= stageRdData;
        end
    end

    assign phaseUOut         = outLevel_reg[0];
    assign phaseVOut         = outLevel_reg[1];
    assign phaseWOut         = outLevel_reg[2];
    assign matchIrqStatus    = matchIrqStatus_reg;
    assign convTriggerStatus = convTriggerStatus_reg;
    assign matchIrq          = matchIrq_reg;
    assign convTrigger       = convTrigger_reg;
    assign wordRdData        = wordRdData_reg;
    assign wordRdValid       = wordRdValid_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    AST_DISABLED_LOW: assert property (!unitEnable |=> outLevel_reg == 3'h0)
        else $error("Outputs not low while disabled.");
    AST_IRQ_CLEAR_ALL: assert property (matchIrqClearWr && matchIrqClearData == `ARGW_CLEAR_ALL && irqSet == 3'h0
        |=> matchIrqStatus == 3'h0)
        else $error("Match status not cleared by seven.");
    AST_TRIG_CLEAR_ALL: assert property (convTriggerClearWr && convTriggerClearData == `ARGW_CLEAR_ALL
        && trigSet == 3'h0 |=> convTriggerStatus == 3'h0)
        else $error("Trigger status not cleared by seven.");
    AST_IRQ_SET_WINS: assert property (irqSet != 3'h0 |=> (matchIrqStatus & $past(irqSet)) == $past(irqSet)
        && matchIrq)
        else $error("Match event lost.");
    AST_IRQ_LOWER_HALF: assert property (irqSet != 3'h0 && irqLowerHalfEnable |-> adjAngle < `ARGW_HALF_TURN)
        else $error("Match interrupt at or above half turn.");
    AST_TRIG_LOWER_HALF: assert property (trigSet != 3'h0 && trigLowerHalfEnable |-> adjAngle < `ARGW_HALF_TURN)
        else $error("Trigger at or above half turn.");
    AST_IRQ_U_ONLY: assert property (irqPhaseEnable == 2'h0 |-> irqSet[2:1] == 2'h0)
        else $error("Match interrupt from phase other than U.");
    AST_TRIG_U_ONLY: assert property (trigPhaseEnable == 2'h0 |-> trigSet[2:1] == 2'h0)
        else $error("Trigger from phase other than U.");
    AST_IRQ_SELECT: assert property (irqSet[0] |-> phaseUIrqSelect[curArea_reg[0]])
        else $error("Phase U interrupt without select bit.");
    AST_TRIG_SELECT: assert property (trigSet[0] |-> phaseUTriggerSelect[curArea_reg[0]])
        else $error("Phase U trigger without select bit.");
    AST_BATCH_HOLD: assert property (wrOk && compareTransferMode == `ARGW_XFER_BATCH && !copyWrPend_reg
        |-> !activeMem.wrEn)
        else $error("Batch write reached active table.");
    AST_COPY_LENGTH: assert property (copyStart |=> state_reg == argw_pkg::S_COPY ##95
        state_reg == argw_pkg::S_COPY ##1 state_reg != argw_pkg::S_COPY)
        else $error("Transfer did not copy ninety-six words.");

    COV_U_IRQ: cover property (irqSet[0]);
    COV_TRIGGER: cover property (convTrigger);
    COV_COPY_DONE: cover property (state_reg == argw_pkg::S_COPY ##1 state_reg == argw_pkg::S_IDLE);
    COV_U_TOGGLE: cover property (!phaseUOut ##[1:400] phaseUOut);

endmodule

/* verification/angle_source.sv */
`timescale 1ns/1ps
module angle_source (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Request from the bench.
    input  wire logic [11:0] newAngle,
    input  wire logic        load,
    // Angle towards the generator.
    output logic      [11:0] elecAngle,
    output logic             elecAngleValid
);
    always_ff @(posedge clk_sys)
    begin
        elecAngleValid <= load & ~reset;
        if (reset)
            elecAngle <= 12'h000;
        else if (load)
            elecAngle <= newAngle;
    end
endmodule

/* verification/tb_angle_rectangle_wave_gen.sv */
`timescale 1ns/1ps
module tb_angle_rectangle_wave_gen;
    logic        clk_sys = 1'b0, reset = 1'b1, load = 1'b0, unitEnable = 1'b0, channelIndependent = 1'b1;
    logic        rotationDirection = 1'b0, compareTransferMode = 1'b0, transferGo = 1'b0, wordWrEn = 1'b0;
    logic        matchIrqClearWr = 1'b0, convTriggerClearWr = 1'b0, irqLowerHalfEnable = 1'b1, wordRdEn = 1'b0;
    logic        trigLowerHalfEnable = 1'b1, elecAngleValid, wordRdValid, phaseUOut, phaseVOut, phaseWOut;
    logic        matchIrq, convTrigger;
    logic [1:0]  waveformModeCtrl = 2'h0, irqPhaseEnable = 2'h0, trigPhaseEnable = 2'h0;
    logic [1:0]  writePhaseSelect = 2'h0, readPhaseSelect = 2'h0;
    logic [2:0]  matchIrqClearData = 3'h0, convTriggerClearData = 3'h0, matchIrqStatus, convTriggerStatus, held;
    logic [4:0]  wordWrIndex = 5'h00, wordRdIndex = 5'h00;
    logic [5:0]  phaseUAreaCount = 6'h20, phaseVAreaCount = 6'h20, phaseWAreaCount = 6'h20;
    logic [11:0] newAngle = 12'h000, elecAngle, commonAngleOffset = 12'h000, a;
    logic [11:0] phaseUAngleOffset = 12'h000, phaseVAngleOffset = 12'h000, phaseWAngleOffset = 12'h000;
    logic [15:0] wordWrData = 16'h0000, wordRdData;
    logic [31:0] phaseUIrqSelect = 32'h00000001, phaseVIrqSelect = 32'h0, phaseWIrqSelect = 32'h0;
    logic [31:0] phaseUTriggerSelect = 32'h00000001, phaseVTriggerSelect = 32'h0, phaseWTriggerSelect = 32'h0;
    logic [31:0] seed = 32'h24, r;
    int          mismatches = 0, checks = 0, cycles = 0, irqPulses = 0, trigPulses = 0;

    angle_source src_u (.clk_sys(clk_sys), .reset(reset), .newAngle(newAngle), .load(load),
                        .elecAngle(elecAngle), .elecAngleValid(elecAngleValid));
    angle_rectangle_wave_gen dut_u (.*);

    always #12.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Phase p table: pairs of low and high areas a quarter of 0x100 apart, shifted by 0x40 per phase.
    function logic [15:0] word(input int p, input int k);
        logic [11:0] e;
        e = 12'((k / 2) * 256 + 64 * p + 64 * (k % 2));
        return {k[0], 3'h0, e};
    endfunction
    // Level of phase table p at angle x when n areas are used; a count of zero means all thirty-two.
    function logic lvl(input int p, input logic [5:0] n, input logic [11:0] x);
        logic [15:0] w;
        for (int k = 0; k < ((n == 6'h00) ? 32 : int'(n)); k++)
        begin
            w = word(p, k);
            if (x < w[11:0])
                return w[15];
        end
        w = word(p, 0);
        return w[15];
    endfunction
    task tick(); @(posedge clk_sys); #2; endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task move(input logic [11:0] x); newAngle = x; load = 1'b1; tick(); load = 1'b0; repeat (200) tick(); endtask
    task clear(); matchIrqClearWr = 1'b1; matchIrqClearData = 3'h7; convTriggerClearWr = 1'b1;
        convTriggerClearData = 3'h7; tick(); matchIrqClearWr = 1'b0; convTriggerClearWr = 1'b0; tick(); endtask
    task results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin
        cycles++;
        irqPulses += int'(matchIrq);
        trigPulses += int'(convTrigger);
        if (cycles == 20000)
        begin
            mismatches++;
            results();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        #2 reset = 1'b0;
        for (int p = 0; p < 3; p++)
        begin
            writePhaseSelect = 2'(p);
            for (int k = 0; k < 32; k++)
            begin
                wordWrEn = 1'b1; wordWrIndex = 5'(k); wordWrData = word(p, k); tick();
            end
        end
        wordWrEn = 1'b0; unitEnable = 1'b1; move(12'h020);
        chk(phaseUOut, 1'b0);
        readPhaseSelect = 2'h1; wordRdEn = 1'b1; wordRdIndex = 5'h05; tick(); wordRdEn = 1'b0; tick();
        chk({wordRdValid, wordRdData}, {1'b1, word(1, 5)});
        $display("test done: staged words");
        // Long enough for the scan in flight, the copy and the rescan that follows it.
        transferGo = 1'b1; tick(); transferGo = 1'b0; repeat (500) tick();
        chk({phaseUOut, phaseVOut, phaseWOut},
            {lvl(0, 6'h20, 12'h020), lvl(1, 6'h20, 12'h020), lvl(2, 6'h20, 12'h020)});
        move(12'hF50); clear();
        chk({matchIrqStatus, convTriggerStatus}, 6'h00);
        irqPulses = 0;
        trigPulses = 0;
        move(12'h010);
        chk({matchIrqStatus, convTriggerStatus}, 6'h09);
        chk({irqPulses[7:0], trigPulses[7:0]}, 16'h0101);
        $display("test done: events");
        for (int i = 0; i < 24; i++)
        begin
            r = rnd(); a = r[11:0]; commonAngleOffset = r[23:12];
            r = rnd(); phaseUAngleOffset = r[11:0]; phaseVAngleOffset = r[23:12];
            phaseUAreaCount = r[24] ? 6'h00 : 6'h06; phaseVAreaCount = r[25] ? 6'h00 : 6'h20;
            r = rnd(); phaseWAngleOffset = r[11:0]; phaseWAreaCount = r[24] ? 6'h00 : 6'h20;
            rotationDirection = r[26]; channelIndependent = r[27];
            phaseVIrqSelect = rnd(); phaseWTriggerSelect = rnd();
            if (i == 0)
                a = 12'hFFF;
            move(a);
            // Reverse rotation negates the angle; a shared table means every phase reads the U table.
            a = rotationDirection ? 12'(12'h000 - a) : a;
            held = {lvl(0, phaseUAreaCount, a + commonAngleOffset + phaseUAngleOffset),
                lvl(int'(channelIndependent), phaseVAreaCount, a + commonAngleOffset + phaseVAngleOffset),
                lvl(2 * int'(channelIndependent), phaseWAreaCount, a + commonAngleOffset + phaseWAngleOffset)};
            chk({phaseUOut, phaseVOut, phaseWOut}, held);
        end
        // Any mode but sawtooth freezes the comparator, so the last levels must stay.
        waveformModeCtrl = 2'h1;
        move(a ^ 12'h800);
        chk({phaseUOut, phaseVOut, phaseWOut}, held);
        waveformModeCtrl = 2'h0;
        chk({matchIrqStatus[2:1], convTriggerStatus[2:1]}, 4'h0);
        $display("test done: random angles");
        results();
    end
endmodule
